// >>> logic/lin_uart_pkg.sv
// Register map, field positions, reset values and states of the serial and bus master controller.
package lin_uart_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SCR = 8'h00;
	localparam logic [7:0] OFS_SSR = 8'h04;
	localparam logic [7:0] OFS_LC1 = 8'h08;
	localparam logic [7:0] OFS_LC2 = 8'h0c;
	localparam logic [7:0] OFS_FSR = 8'h10;
	localparam logic [7:0] OFS_LSR = 8'h14;
	localparam logic [7:0] OFS_LESR = 8'h18;
	localparam logic [7:0] OFS_IER = 8'h1c;
	localparam logic [7:0] OFS_BUFLO = 8'h20;
	localparam logic [7:0] OFS_BUFHI = 8'h24;
	localparam logic [7:0] OFS_DIV = 8'h28;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SCR_UART = 0;
	localparam int SCR_TX_ENABLE = 1;
	localparam int SCR_RX_ENABLE = 2;
	localparam int SCR_PEN = 3;
	localparam int SCR_ODD = 4;
	localparam int SCR_NINE = 5;
	localparam int SCR_TXCNT = 6;
	localparam int SCR_RXCNT = 8;
	localparam int LC1_INIT = 0;
	localparam int LC1_MASTER = 1;
	localparam int LC1_LOCK = 2;
	localparam int FSR_DIR = 8;
	localparam int FSR_CCS = 9;
	localparam int FSR_LEN = 10;
	localparam int IER_BE = 0;
	localparam int IER_FE = 1;
	localparam int IER_CE = 2;
	localparam int IER_BO = 3;
	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [9:0] SCR_RST = 10'h000;
	localparam logic [2:0] LC1_RST = 3'h1;
	localparam logic [15:0] FSR_MASK = 16'hff3f;
	localparam logic [15:0] DIV_RST = 16'h0363;
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam logic [3:0] BREAK_BITS = 4'hd;
	localparam logic [6:0] BUF_BYTES = 7'h08;
	localparam int RX_SLOT0 = 4;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_UTX = 8'h02,
		ST_BRK = 8'h04,
		ST_SYNC = 8'h08,
		ST_PID = 8'h10,
		ST_TXD = 8'h20,
		ST_HOLD = 8'h40,
		ST_RXD = 8'h80
	} state_t;
endpackage

// >>> logic/lin_bit_engine.sv
// Bit-level serialiser and sampler with break generation and read-back check.
`timescale 1ns/1ps
module lin_bit_engine (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [15:0] div,
	input wire logic nine,
	input wire logic tx_go,
	input wire logic [8:0] tx_data,
	input wire logic tx_brk,
	input wire logic chk_en,
	input wire logic rx_s,
	output logic txd,
	output logic tx_done,
	output logic bit_err,
	output logic rx_done,
	output logic [8:0] rx_data,
	output logic rx_ferr
);
	logic [13:0] tsh_r;
	logic [3:0] tcnt_r;
	logic [15:0] tdiv_r;
	logic tbusy_r;
	logic terr_r;
	logic [10:0] rsh_r;
	logic [3:0] rcnt_r;
	logic [15:0] rdiv_r;
	logic rbusy_r;
	logic rarm_r;

	localparam logic [3:0] BREAK_BITS = lin_uart_pkg::BREAK_BITS;
	wire [15:0] half = {1'b0, div[15:1]};
	wire [13:0] frame = tx_brk ? 14'h2000 :
		nine ? {4'h1, tx_data, 1'b0} : {5'h01, tx_data[7:0], 1'b0};
	wire [3:0] flen = tx_brk ? BREAK_BITS + 4'h1 : nine ? 4'hb : 4'ha;

	assign txd = tbusy_r ? tsh_r[0] : 1'b1;

	// ----------------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tsh_r <= 14'h3fff;
			tcnt_r <= 4'h0;
			tdiv_r <= 16'h0000;
			tbusy_r <= 1'b0;
			terr_r <= 1'b0;
			tx_done <= 1'b0;
			bit_err <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			bit_err <= 1'b0;
			if (!tbusy_r) begin
				if (tx_go) begin
					tbusy_r <= 1'b1;
					tsh_r <= frame;
					tcnt_r <= flen;
					tdiv_r <= div;
					terr_r <= 1'b0;
				end
			end else if (tdiv_r == 16'h0000) begin
				// A corrupted bit is finished before the frame is cut short.
				if (terr_r || tcnt_r == 4'h1) begin
					tbusy_r <= 1'b0;
					tx_done <= ~terr_r;
					bit_err <= terr_r;
				end else begin
					tsh_r <= {1'b1, tsh_r[13:1]};
					tcnt_r <= tcnt_r - 4'h1;
					tdiv_r <= div;
				end
			end else begin
				tdiv_r <= tdiv_r - 16'h0001;
				if (chk_en && tdiv_r == half && rx_s != tsh_r[0]) begin
					terr_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	// The sampler rearms only after seeing a recessive level, so a break is one frame.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rsh_r <= 11'h000;
			rcnt_r <= 4'h0;
			rdiv_r <= 16'h0000;
			rbusy_r <= 1'b0;
			rarm_r <= 1'b0;
			rx_done <= 1'b0;
			rx_data <= 9'h000;
			rx_ferr <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rbusy_r) begin
				if (rx_s) begin
					rarm_r <= 1'b1;
				end else if (rarm_r) begin
					rbusy_r <= 1'b1;
					rarm_r <= 1'b0;
					rdiv_r <= half;
					rcnt_r <= nine ? 4'hb : 4'ha;
				end
			end else if (rdiv_r != 16'h0000) begin
				rdiv_r <= rdiv_r - 16'h0001;
			end else if (rx_s && rcnt_r == (nine ? 4'hb : 4'ha)) begin
				rbusy_r <= 1'b0;
			end else begin
				rdiv_r <= div;
				rsh_r <= {rx_s, rsh_r[10:1]};
				rcnt_r <= rcnt_r - 4'h1;
				if (rcnt_r == 4'h1) begin
					rbusy_r <= 1'b0;
					rx_done <= 1'b1;
					rx_ferr <= ~rx_s;
					rx_data <= nine ? rsh_r[10:2] : {1'b0, rsh_r[10:3]};
				end
			end
		end
	end
endmodule

// >>> logic/lin_uart_master_controller.sv
// Top of the serial controller: register slave, message buffer, UART and bus master sequencing.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - With parity enabled, eight-bit frames carry seven data bits plus parity, odd parity inverts it.
// - Nine-bit frames always carry eight data bits plus a parity bit.
// - In UART mode the low buffer word transmits and the high word receives.
// - UART mode and transmit enable set, writing slot zero starts sending.
// - Send the programmed byte count, at most four, then flag transmit complete.
// - Clearing transmit enable finishes the current send and blocks further ones.
// - Receiver runs outside init with receive enable; flag after the byte count.
// - Clearing receive enable finishes the current message, then reception stops.
// - Parity errors set a per-byte flag only; framing errors may interrupt.
// - A byte arriving while the buffer is unread sets overrun and may interrupt.
// - Without lock the newest message overwrites; with lock it is dropped.
// - Clock gating is acknowledged only when idle and no started UART receive message still awaits bytes.
// - Master select chosen, a header request sends break, sync and identifier.
// - As publisher the buffer bytes and the chosen checksum follow the header.
// - Successful publish sets transmit complete, errors go to the error register.
// - Long publishes pause after eight bytes until software clears the drained flag.
// - Direction set publishes from the buffer, clear subscribes into it.
// - Subscribed bytes land in the buffer; success flags receive complete.
// - Long subscriptions flag a filled buffer every eight bytes.
// - A read-back mismatch ends the frame after that bit and may interrupt.
// - A dominant stop bit is a framing error; go idle and may interrupt.
// - The response length field holds the byte count minus one.
// - Checksum kind zero covers identifier and data, one covers data only.
module lin_uart_master_controller (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rxd,
	output logic txd,
	output logic irq,
	input wire logic gate_req,
	output logic gate_ack
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic par_bit(input logic [7:0] d, input logic seven, input logic odd);
		par_bit = (seven ? ^d[6:0] : ^d) ^ odd;
	endfunction

	function automatic logic [7:0] cks_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		cks_add = s[7:0] + {7'h00, s[8]};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lin_uart_pkg::state_t state_r;
	logic [9:0] scr_r;
	logic [2:0] lc1_r;
	logic [15:0] fsr_r;
	logic [3:0] ier_r;
	logic [15:0] div_r;
	logic [7:0] buf_r [0:7];
	logic hdr_req_r, disc_r;
	logic u_txc_r, u_rxc_r, u_fe_r, u_bof_r, u_rmb_r;
	logic [3:0] u_pe_r;
	logic l_txc_r, l_rxc_r, drain_r, fill_r;
	logic e_bit_r, e_fe_r, e_ck_r;
	logic [6:0] idx_r;
	logic [7:0] cks_r;
	logic [1:0] ucnt_r;
	logic rx_msg_r;
	logic go_r, brk_r;
	logic [8:0] tdat_r;
	logic rxd_m_r, rxd_s_r, greq_m_r, greq_s_r;
	logic [8:0] rdat;
	logic tx_ev, rx_ev, berr, ferr, eng_txd;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land at the edge where the master sees ack, while it still holds the request.
	wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
	wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
	wire wr_scr = wr && adr == lin_uart_pkg::OFS_SCR;
	wire wr_ssr = wr && adr == lin_uart_pkg::OFS_SSR;
	wire wr_lc1 = wr && adr == lin_uart_pkg::OFS_LC1;
	wire wr_lc2 = wr && adr == lin_uart_pkg::OFS_LC2;
	wire wr_fsr = wr && adr == lin_uart_pkg::OFS_FSR;
	wire wr_lsr = wr && adr == lin_uart_pkg::OFS_LSR;
	wire wr_lesr = wr && adr == lin_uart_pkg::OFS_LESR;
	wire wr_ier = wr && adr == lin_uart_pkg::OFS_IER;
	wire wr_lo = wr && adr == lin_uart_pkg::OFS_BUFLO;
	wire wr_hi = wr && adr == lin_uart_pkg::OFS_BUFHI;
	wire wr_div = wr && adr == lin_uart_pkg::OFS_DIV;
	wire [31:0] w1c = wb_dat_i;

	wire uart = scr_r[lin_uart_pkg::SCR_UART];
	wire nine = uart & scr_r[lin_uart_pkg::SCR_NINE];
	wire pen = scr_r[lin_uart_pkg::SCR_PEN];
	wire odd = scr_r[lin_uart_pkg::SCR_ODD];
	wire [1:0] utx_last = scr_r[lin_uart_pkg::SCR_TXCNT +: 2];
	wire [1:0] urx_last = scr_r[lin_uart_pkg::SCR_RXCNT +: 2];
	wire init = lc1_r[lin_uart_pkg::LC1_INIT];
	wire lock = lc1_r[lin_uart_pkg::LC1_LOCK];
	wire [5:0] fid = fsr_r[5:0];
	wire dir = fsr_r[lin_uart_pkg::FSR_DIR];
	wire checksum_kind_select = fsr_r[lin_uart_pkg::FSR_CCS];
	wire [6:0] dlast = {1'b0, fsr_r[lin_uart_pkg::FSR_LEN +: 6]};
	wire [6:0] ckidx = dlast + 7'h01;
	wire [6:0] idx_inc = idx_r + 7'h01;
	wire [7:0] pid = {~(fid[1] ^ fid[3] ^ fid[4] ^ fid[5]), fid[0] ^ fid[1] ^ fid[2] ^ fid[4], fid};
	wire idle = state_r == lin_uart_pkg::ST_IDLE;

	// UART frames: nine-bit adds parity over eight bits, eight-bit may replace bit 7.
	function automatic logic [8:0] uframe(input logic [7:0] b);
		if (nine) begin
			uframe = {par_bit(b, 1'b0, odd), b};
		end else if (pen) begin
			uframe = {1'b0, par_bit(b, 1'b1, odd), b[6:0]};
		end else begin
			uframe = {1'b0, b};
		end
	endfunction

	// Transmission is only started from idle, so a cleared enable stops later triggers.
	wire u_start = idle & uart & scr_r[lin_uart_pkg::SCR_TX_ENABLE] & wr_lo & wb_sel_i[0];
	wire l_start = idle & ~uart & lc1_r[lin_uart_pkg::LC1_MASTER] & ~init & hdr_req_r;
	wire lin_tx = |(state_r & (lin_uart_pkg::ST_BRK | lin_uart_pkg::ST_SYNC |
		lin_uart_pkg::ST_PID | lin_uart_pkg::ST_TXD | lin_uart_pkg::ST_HOLD));
	wire in_txd = state_r == lin_uart_pkg::ST_TXD;
	wire in_rxd = state_r == lin_uart_pkg::ST_RXD;
	wire txd_ev = in_txd & tx_ev;
	wire rxd_ev = in_rxd & rx_ev;
	wire rxd_data = rxd_ev & ~ferr & idx_r <= dlast;
	wire rxd_ck = rxd_ev & ~ferr & idx_r == ckidx;

	// UART reception continues to the end of a started message even if disabled.
	wire u_acc = uart & ~init & rx_ev & (scr_r[lin_uart_pkg::SCR_RX_ENABLE] | rx_msg_r);
	wire u_end = u_acc & ucnt_r == urx_last;
	wire u_keep = ~(lock & u_rmb_r);
	wire u_perr = nine ? rdat[8] != par_bit(rdat[7:0], 1'b0, odd) :
		pen & (rdat[7] != par_bit(rdat[7:0], 1'b1, odd));

	wire [31:0] buf_lo = {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
	wire [31:0] buf_hi = {buf_r[7], buf_r[6], buf_r[5], buf_r[4]};
	wire [31:0] rd_mux =
		adr == lin_uart_pkg::OFS_SCR ? {22'h0, scr_r} :
		adr == lin_uart_pkg::OFS_SSR ? {23'h0, u_pe_r, u_rmb_r, u_bof_r, u_fe_r, u_rxc_r, u_txc_r} :
		adr == lin_uart_pkg::OFS_LC1 ? {29'h0, lc1_r} :
		adr == lin_uart_pkg::OFS_LC2 ? {30'h0, disc_r, hdr_req_r} :
		adr == lin_uart_pkg::OFS_FSR ? {16'h0, fsr_r} :
		adr == lin_uart_pkg::OFS_LSR ? {27'h0, ~idle, fill_r, drain_r, l_rxc_r, l_txc_r} :
		adr == lin_uart_pkg::OFS_LESR ? {29'h0, e_ck_r, e_fe_r, e_bit_r} :
		adr == lin_uart_pkg::OFS_IER ? {28'h0, ier_r} :
		adr == lin_uart_pkg::OFS_BUFLO ? buf_lo :
		adr == lin_uart_pkg::OFS_BUFHI ? buf_hi :
		adr == lin_uart_pkg::OFS_DIV ? {16'h0, div_r} : 32'h0;

	wire irq_nxt = ((u_fe_r | e_fe_r) & ier_r[lin_uart_pkg::IER_FE]) |
		(u_bof_r & ier_r[lin_uart_pkg::IER_BO]) |
		(e_bit_r & ier_r[lin_uart_pkg::IER_BE]) |
		(e_ck_r & ier_r[lin_uart_pkg::IER_CE]);

	lin_bit_engine eng (
		.mclk(mclk),
		.rstn(rstn),
		.div(div_r),
		.nine(nine),
		.tx_go(go_r),
		.tx_data(tdat_r),
		.tx_brk(brk_r),
		.chk_en(lin_tx),
		.rx_s(rxd_s_r),
		.txd(eng_txd),
		.tx_done(tx_ev),
		.bit_err(berr),
		.rx_done(rx_ev),
		.rx_data(rdat),
		.rx_ferr(ferr)
	);

	// ----------------------------------------------------------------
	// Bus slave, pins and configuration
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			txd <= 1'b1;
			irq <= 1'b0;
			gate_ack <= 1'b0;
			{rxd_m_r, rxd_s_r, greq_m_r, greq_s_r} <= 4'hc;
			scr_r <= lin_uart_pkg::SCR_RST;
			lc1_r <= lin_uart_pkg::LC1_RST;
			fsr_r <= 16'h0;
			ier_r <= 4'h0;
			div_r <= lin_uart_pkg::DIV_RST;
			hdr_req_r <= 1'b0;
			disc_r <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h0;
			txd <= eng_txd;
			irq <= irq_nxt;
			{rxd_m_r, rxd_s_r} <= {rxd, rxd_m_r};
			{greq_m_r, greq_s_r} <= {gate_req, greq_m_r};
			gate_ack <= greq_s_r & idle & ~rx_msg_r;
			if (wr_scr) scr_r <= wb_dat_i[9:0];
			if (wr_lc1) lc1_r <= wb_dat_i[2:0];
			if (wr_fsr) fsr_r <= wb_dat_i[15:0] & lin_uart_pkg::FSR_MASK;
			if (wr_ier) ier_r <= wb_dat_i[3:0];
			if (wr_div) div_r <= wb_dat_i[15:0];
			hdr_req_r <= (wr_lc2 & wb_dat_i[0]) | (hdr_req_r & ~l_start);
			disc_r <= (wr_lc2 ? wb_dat_i[1] : disc_r) & ~(state_r == lin_uart_pkg::ST_PID & tx_ev);
		end
	end

	// ----------------------------------------------------------------
	// Status flags: a hardware set wins over a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{u_txc_r, u_rxc_r, u_fe_r, u_bof_r, u_rmb_r} <= 5'h0;
			u_pe_r <= 4'h0;
			{l_txc_r, l_rxc_r, drain_r, fill_r} <= 4'h0;
			{e_bit_r, e_fe_r, e_ck_r} <= 3'h0;
			ucnt_r <= 2'h0;
			rx_msg_r <= 1'b0;
		end else begin
			u_txc_r <= (state_r == lin_uart_pkg::ST_UTX & tx_ev & idx_r[1:0] == utx_last) |
				(u_txc_r & ~(wr_ssr & w1c[0]));
			u_rxc_r <= (u_end & u_keep) | (u_rxc_r & ~(wr_ssr & w1c[1]));
			u_fe_r <= (u_acc & ferr) | (u_fe_r & ~(wr_ssr & w1c[2]));
			u_bof_r <= (u_acc & u_rmb_r) | (u_bof_r & ~(wr_ssr & w1c[3]));
			u_rmb_r <= u_end | (u_rmb_r & ~(wr_ssr & w1c[4]));
			for (int i = 0; i < 4; i++) begin
				u_pe_r[i] <= (u_acc & u_perr & ucnt_r == 2'(i)) | (u_pe_r[i] & ~(wr_ssr & w1c[5 + i]));
			end
			if (u_acc) begin
				ucnt_r <= u_end ? 2'h0 : ucnt_r + 2'h1;
				rx_msg_r <= ~u_end;
			end
			l_txc_r <= (txd_ev & idx_r == ckidx) | (l_txc_r & ~(wr_lsr & w1c[0]));
			l_rxc_r <= (rxd_ck & rdat[7:0] == ~cks_r) | (l_rxc_r & ~(wr_lsr & w1c[1]));
			drain_r <= (txd_ev & idx_r < dlast & idx_r[2:0] == 3'h7) |
				(drain_r & ~(wr_lsr & w1c[2]));
			fill_r <= (rxd_data & idx_r < dlast & idx_r[2:0] == 3'h7) |
				(fill_r & ~(wr_lsr & w1c[3]));
			e_bit_r <= (berr & lin_tx) | (e_bit_r & ~(wr_lesr & w1c[0]));
			e_fe_r <= (rxd_ev & ferr) | (e_fe_r & ~(wr_lesr & w1c[1]));
			e_ck_r <= (rxd_ck & rdat[7:0] != ~cks_r) | (e_ck_r & ~(wr_lesr & w1c[2]));
		end
	end

	// ----------------------------------------------------------------
	// Message buffer: received bytes take priority over a bus write
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) buf_r[i] <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (rxd_data && idx_r[2:0] == 3'(i)) begin
					buf_r[i] <= rdat[7:0];
				end else if (u_acc && u_keep && i == lin_uart_pkg::RX_SLOT0 + int'(ucnt_r)) begin
					buf_r[i] <= rdat[7:0];
				end else if ((i < 4 ? wr_lo : wr_hi) && wb_sel_i[i % 4]) begin
					buf_r[i] <= wb_dat_i[8 * (i % 4) +: 8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= lin_uart_pkg::ST_IDLE;
			idx_r <= 7'h0;
			cks_r <= 8'h0;
			go_r <= 1'b0;
			brk_r <= 1'b0;
			tdat_r <= 9'h0;
		end else begin
			go_r <= 1'b0;
			if (lin_tx && berr) begin
				state_r <= lin_uart_pkg::ST_IDLE;
			end else begin
				unique case (state_r)
					lin_uart_pkg::ST_IDLE: begin
						idx_r <= 7'h0;
						if (u_start) begin
							state_r <= lin_uart_pkg::ST_UTX;
							go_r <= 1'b1;
							brk_r <= 1'b0;
							tdat_r <= uframe(wb_dat_i[7:0]);
						end else if (l_start) begin
							state_r <= lin_uart_pkg::ST_BRK;
							go_r <= 1'b1;
							brk_r <= 1'b1;
						end
					end
					lin_uart_pkg::ST_UTX: if (tx_ev) begin
						if (idx_r[1:0] == utx_last) begin
							state_r <= lin_uart_pkg::ST_IDLE;
						end else begin
							idx_r <= idx_inc;
							go_r <= 1'b1;
							tdat_r <= uframe(buf_r[idx_inc[1:0]]);
						end
					end
					lin_uart_pkg::ST_BRK: if (tx_ev) begin
						state_r <= lin_uart_pkg::ST_SYNC;
						go_r <= 1'b1;
						brk_r <= 1'b0;
						tdat_r <= {1'b0, lin_uart_pkg::SYNC_BYTE};
					end
					lin_uart_pkg::ST_SYNC: if (tx_ev) begin
						state_r <= lin_uart_pkg::ST_PID;
						go_r <= 1'b1;
						tdat_r <= {1'b0, pid};
						cks_r <= checksum_kind_select ? 8'h00 : pid;
					end
					lin_uart_pkg::ST_PID: if (tx_ev) begin
						if (dir) begin
							state_r <= lin_uart_pkg::ST_TXD;
							go_r <= 1'b1;
							tdat_r <= {1'b0, buf_r[0]};
							cks_r <= cks_add(cks_r, buf_r[0]);
						end else if (disc_r) begin
							state_r <= lin_uart_pkg::ST_IDLE;
						end else begin
							state_r <= lin_uart_pkg::ST_RXD;
						end
					end
					lin_uart_pkg::ST_TXD: if (tx_ev) begin
						idx_r <= idx_inc;
						if (idx_r == ckidx) begin
							state_r <= lin_uart_pkg::ST_IDLE;
						end else if (idx_r == dlast) begin
							go_r <= 1'b1;
							tdat_r <= {1'b0, ~cks_r};
						end else if (idx_r[2:0] == 3'h7) begin
							state_r <= lin_uart_pkg::ST_HOLD;
						end else begin
							go_r <= 1'b1;
							tdat_r <= {1'b0, buf_r[idx_inc[2:0]]};
							cks_r <= cks_add(cks_r, buf_r[idx_inc[2:0]]);
						end
					end
					lin_uart_pkg::ST_HOLD: if (!drain_r) begin
						state_r <= lin_uart_pkg::ST_TXD;
						go_r <= 1'b1;
						tdat_r <= {1'b0, buf_r[idx_r[2:0]]};
						cks_r <= cks_add(cks_r, buf_r[idx_r[2:0]]);
					end
					lin_uart_pkg::ST_RXD: if (rx_ev) begin
						idx_r <= idx_inc;
						if (ferr || idx_r == ckidx) begin
							state_r <= lin_uart_pkg::ST_IDLE;
						end else begin
							cks_r <= cks_add(cks_r, rdat[7:0]);
						end
					end
					default: state_r <= lin_uart_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule

// >>> bench/serial_peer.sv
// Line-side serial peer: records frames seen on txd and sends frames on rxd.
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT = 8
) (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got_q[$];
	int nb = 8;
	logic drv = 1'b1;
	logic echo = 1'b0;
	logic txd_d = 1'b1;
	// Echo loops txd back onto rxd, as a shared bus wire would, for the read-back check.
	always @(posedge mclk) txd_d <= txd;
	assign rxd = echo ? txd_d : drv;
	// A frame whose stop bit is not high is dropped, so the count check catches it.
	always begin
		logic [8:0] f;
		f = '0;
		@(negedge txd);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < nb; i++) begin
			repeat (BIT) @(posedge mclk);
			f[i] = txd;
		end
		repeat (BIT) @(posedge mclk);
		if (txd === 1'b1) got_q.push_back(f);
	end
	task automatic send(input logic [8:0] f, input logic stop);
		drv <= 1'b0;
		repeat (BIT) @(posedge mclk);
		for (int i = 0; i < nb; i++) begin
			drv <= f[i];
			repeat (BIT) @(posedge mclk);
		end
		drv <= stop;
		repeat (BIT) @(posedge mclk);
		drv <= 1'b1;
		repeat (BIT) @(posedge mclk);
	endtask
endmodule

// >>> bench/lin_uart_checker.sv
// Port-level assertions for the serial controller.
`timescale 1ns/1ps
module lin_uart_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic txd,
	input wire logic irq,
	input wire logic gate_req,
	input wire logic gate_ack
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h30
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_reset_idle_out: assert property ($rose(rstn) |-> txd && !irq && !gate_ack)
		else $error("outputs not idle after reset");
	a_gate_needs_req: assert property ($rose(gate_ack) |-> $past(gate_req, 2) && txd)
		else $error("gate ack without request or while sending");
	a_gate_ack_drop: assert property (!gate_req [*4] |-> !gate_ack)
		else $error("gate ack held without request");
	c_bus_write: cover property (wb_ack_o && wb_we_i);
	c_bus_read: cover property (wb_ack_o && !wb_we_i);
	c_gate_given: cover property ($rose(gate_ack));
endmodule
bind lin_uart_master_controller lin_uart_checker i_chk (.mclk(mclk), .rstn(rstn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd(txd), .irq(irq),
	.gate_req(gate_req), .gate_ack(gate_ack));

// >>> bench/tb_top.sv
// Self-checking bench: UART traffic, overrun, framing and clock gating.
`timescale 1ns/1ps
module tb_top;
	logic mclk, rstn, cyc, stb, we, ack, txd, rxd, irq, gate_req, gate_ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q, d;
	logic [8:0] f[4];
	logic [2:0] cfgs[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
	int seed = 68701;
	int n_fail, tests_run, n, j;
	lin_uart_master_controller i_dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rxd(rxd), .txd(txd), .irq(irq),
		.gate_req(gate_req), .gate_ack(gate_ack));
	serial_peer #(.BIT(8)) i_peer (.mclk(mclk), .txd(txd), .rxd(rxd));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, v};
		@(posedge mclk);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge mclk);
			k++;
		end
		q = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge mclk);
		if (k >= 20) begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic poll(input logic [7:0] a, input int b);
		int k;
		k = 0;
		q = '0;
		while (q[b] !== 1'b1 && k < 500) begin
			bus(1'b0, a, 32'h0);
			k++;
		end
		if (k >= 500) begin
			n_fail++;
			end_of_test();
		end
	endtask
	// Parity rides in bit 7 over seven data bits, or in bit 8 for nine-bit frames.
	function automatic logic [8:0] frame(input logic [7:0] v, input logic [2:0] c);
		if (c[2]) return {^v ^ c[1], v};
		if (c[0]) return {1'b0, ^v[6:0] ^ c[1], v[6:0]};
		return {1'b0, v};
	endfunction
	initial begin
		{rstn, cyc, stb, we, adr, sel, dat, gate_req} = '0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		bus(1'b0, lin_uart_pkg::OFS_LC1, 32'h0);
		chk("init", q[0], 1'b1);
		bus(1'b0, 8'h30, 32'h0);
		bus(1'b1, lin_uart_pkg::OFS_DIV, 32'h7);
		bus(1'b1, lin_uart_pkg::OFS_BUFLO, 32'h5a);
		bus(1'b1, lin_uart_pkg::OFS_LC1, 32'h0);
		foreach (cfgs[k]) begin
			n = ($random(seed) & 3) + 1;
			d = $random(seed);
			i_peer.nb = cfgs[k][2] ? 9 : 8;
			bus(1'b1, lin_uart_pkg::OFS_SCR, {22'h0, 2'(n - 1), 2'(n - 1), cfgs[k], 3'h7});
			bus(1'b1, lin_uart_pkg::OFS_BUFLO, d);
			poll(lin_uart_pkg::OFS_SSR, 0);
			chk("frames", i_peer.got_q.size(), n);
			for (int i = 0; i < n; i++) chk("tx", i_peer.got_q[i], frame(d[8*i+:8], cfgs[k]));
			j = $random(seed) & 3;
			for (int i = 0; i < n; i++) begin
				f[i] = frame(d[8*i+:8], cfgs[k]);
				if (i == j && cfgs[k] != 3'h0) f[i][cfgs[k][2] ? 8 : 7] ^= 1'b1;
				i_peer.send(f[i], 1'b1);
			end
			poll(lin_uart_pkg::OFS_SSR, 1);
			chk("perr", q[8:5], (cfgs[k] != 3'h0 && j < n) ? 4'(1 << j) : 4'h0);
			bus(1'b0, lin_uart_pkg::OFS_BUFHI, 32'h0);
			for (int i = 0; i < n; i++) chk("rx", q[8*i+:8], f[i][7:0]);
			bus(1'b1, lin_uart_pkg::OFS_SSR, 32'h1ff);
			i_peer.got_q.delete();
		end
		bus(1'b1, lin_uart_pkg::OFS_SCR, 32'h7);
		i_peer.nb = 8;
		for (int l = 1; l >= 0; l--) begin
			bus(1'b1, lin_uart_pkg::OFS_LC1, 32'(l) << 2);
			d = $random(seed);
			i_peer.send({1'b0, d[7:0]}, 1'b1);
			i_peer.send({1'b0, d[15:8]}, 1'b1);
			bus(1'b0, lin_uart_pkg::OFS_SSR, 32'h0);
			chk("overrun", q[3], 1'b1);
			bus(1'b0, lin_uart_pkg::OFS_BUFHI, 32'h0);
			chk("kept", q[7:0], l ? d[7:0] : d[15:8]);
			bus(1'b1, lin_uart_pkg::OFS_SSR, 32'h1ff);
		end
		bus(1'b1, lin_uart_pkg::OFS_IER, 32'h2);
		i_peer.send(9'h0a5, 1'b0);
		bus(1'b0, lin_uart_pkg::OFS_SSR, 32'h0);
		chk("framing", q[2], 1'b1);
		chk("irq", irq, 1'b1);
		bus(1'b1, lin_uart_pkg::OFS_SSR, 32'h1ff);
		bus(1'b1, lin_uart_pkg::OFS_SCR, 32'hc3);
		bus(1'b1, lin_uart_pkg::OFS_BUFLO, $random(seed));
		gate_req <= 1'b1;
		bus(1'b0, lin_uart_pkg::OFS_SSR, 32'h0);
		bus(1'b0, lin_uart_pkg::OFS_SSR, 32'h0);
		chk("gate_busy", gate_ack, 1'b0);
		poll(lin_uart_pkg::OFS_SSR, 0);
		n = 0;
		while (gate_ack !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		chk("gate", gate_ack, 1'b1);
		i_peer.got_q.delete();
		i_peer.echo <= 1'b1;
		bus(1'b1, lin_uart_pkg::OFS_SCR, 32'h0);
		bus(1'b1, lin_uart_pkg::OFS_LC1, 32'h2);
		d = $random(seed);
		bus(1'b1, lin_uart_pkg::OFS_BUFLO, d);
		bus(1'b1, lin_uart_pkg::OFS_FSR, 32'h31a);
		bus(1'b1, lin_uart_pkg::OFS_LC2, 32'h1);
		poll(lin_uart_pkg::OFS_LSR, 0);
		chk("sync", i_peer.got_q[0], lin_uart_pkg::SYNC_BYTE);
		chk("data", i_peer.got_q[2], d[7:0]);
		chk("checksum", i_peer.got_q[3], {24'h0, ~d[7:0]});
		bus(1'b0, lin_uart_pkg::OFS_LESR, 32'h0);
		chk("link_err", q, 32'h0);
		bus(1'b1, lin_uart_pkg::OFS_FSR, 32'h1a);
		bus(1'b1, lin_uart_pkg::OFS_LC2, 32'h3);
		repeat (400) @(posedge mclk);
		bus(1'b0, lin_uart_pkg::OFS_LSR, 32'h0);
		chk("discard", q[4], 1'b0);
		end_of_test();
	end
endmodule
